// ==== sgm_defs.svh ====
`ifndef SGM_DEFS_SVH
`define SGM_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define SGM_ADDR_OUT      8'h40
`define SGM_ADDR_IN       8'h41
`define SGM_ADDR_MODE     8'h70

// ****************************************
// Field layout and reset values
// ****************************************
`define SGM_OUT_DATA0     0
`define SGM_OUT_DATA1     1
`define SGM_OUT_DIR0      4
`define SGM_OUT_DIR1      5
`define SGM_OUT_RST       8'h30
`define SGM_MODE_REF_OUT  0
`define SGM_MODE_REF_IN   1
`define SGM_MODE_FOFF     2
`define SGM_MODE_FON      3
`define SGM_MODE_RDY_MISO 4
`define SGM_MODE_RST      8'h00

// ****************************************
// Timing
// ****************************************
`define SGM_CLK_HZ        100000000
`define SGM_MCLK_HZ       4000000
`define SGM_BOOT_US       800
`define SGM_WAKE_US       450
`define SGM_FS_DIV        16

`endif

// ==== sgm_pkg.sv ====
`default_nettype none
`include "sgm_defs.svh"

package sgm_pkg;

    typedef enum logic [1:0] {
        PWR_BOOT,
        PWR_SLEEP,
        PWR_WAKE,
        PWR_RUN
    } sgm_pwr_t;

    typedef struct packed {
        sgm_pwr_t    pwr;
        logic [16:0] cnt;
        logic [4:0]  mdiv;
        logic [7:0]  fdiv;
        logic        fs_tick;
        logic [15:0] rdy_cnt;
        logic        ready;
        logic [7:0]  out_reg;
        logic [7:0]  mode_reg;
        logic [1:0]  pad_s1;
        logic [1:0]  pad_s2;
        logic        low_s1;
        logic        low_s2;
        logic [7:0]  trim;
        logic [7:0]  rdata;
        logic [1:0]  gpio;
        logic [1:0]  gpio_oe;
        logic        ref_out;
        logic        ref_in;
        logic        pump_en;
        logic        pump_bypass;
        logic        miso_rdy_n;
        logic        miso_rdy_oe;
        logic        osc_run;
        logic        conv_ok;
    } sgm_state_t;

    localparam sgm_state_t SGM_RST_STATE = '{
        pwr:        PWR_BOOT,
        out_reg:    `SGM_OUT_RST,
        mode_reg:   `SGM_MODE_RST,
        gpio_oe:    2'h3,
        pump_bypass: 1'b1,
        miso_rdy_n: 1'b1,
        osc_run:    1'b1,
        default:    '0
    };

endpackage

`default_nettype wire

// ==== sgm_gpio_mode_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sgm_defs.svh"

// How it works
// R1: Direction bit 1 enables output driver, input stays active.
// R2: Direction bit 0 keeps the pin input only, driver released.
// R3: Reset sets both direction bits to 1.
// R4: Input register returns raw synchronised pin levels, no debounce.
// R5: Input buffer keeps sampling while the pin is driven.
// R6: Low data bits drive pins with direction 1; data resets to 0.
// R7: Reference select bits bypass digital function of pin zero or one.
// R8: Force-off disables the pump and ties battery to pump output.
// R9: Force-on keeps the pump enabled, overriding force-off.
// R10: Block clocks are divided down from a 4 MHz master tick.
// R11: After reset run oscillator, load trim, stop it, then sleep.
// R12: Sleep is reached within 800 us of reset.
// R13: SPI traffic wakes the oscillator, startup done within 450 us.
// R14: Host starts no conversion while oscillator startup runs.
// R15: Conversion-ready output goes high when a conversion completes.
// R16: Optional active-low ready on the serial data output pin.
// R17: Ready pulse lasts one sampling clock cycle.
module sgm_gpio_mode_ctrl #(
    parameter int BOOT_CYC = `SGM_BOOT_US * (`SGM_CLK_HZ / 1000000),
    parameter int WAKE_CYC = `SGM_WAKE_US * (`SGM_CLK_HZ / 1000000),
    parameter int FS_DIV   = `SGM_FS_DIV
) (
    input  wire logic       clk_i,          // 100 MHz clock
    input  wire logic       rst_i,          // Async reset, active high
    input  wire logic       ce_i,           // Clock enable, freezes all state
    input  wire logic       reg_wr_i,       // Register write strobe
    input  wire logic       reg_rd_i,       // Register read strobe
    input  wire logic [7:0] reg_addr_i,     // Register address
    input  wire logic [7:0] reg_wdata_i,    // Register write data
    output logic      [7:0] reg_rdata_o,    // Register read data
    input  wire logic       spi_wake_i,     // SPI traffic seen, pulse
    input  wire logic       sleep_req_i,    // Return to sleep, pulse
    input  wire logic [7:0] trim_i,         // Fused trim word
    input  wire logic       conv_done_i,    // Conversion finished, pulse
    input  wire logic       spi_busy_i,     // Serial output in use by SPI
    input  wire logic [1:0] gpio_pad_i,     // Pin levels, asynchronous
    output logic      [1:0] gpio_pad_o,     // Pin output levels
    output logic      [1:0] gpio_pad_oe_o,  // Pin output enables
    output logic            ref_out_en_o,   // Reference out on pin zero
    output logic            ref_in_en_o,    // Reference in on pin one
    input  wire logic       battery_supply_low_i,    // Battery below pump threshold
    output logic            pump_en_o,      // Charge pump running
    output logic            pump_bypass_o,  // Battery tied to pump output
    output logic            osc_run_o,      // Oscillator running
    output logic            conv_ok_o,      // Oscillator stable
    output logic            fs_tick_o,      // Sampling clock tick
    output logic            ready_o,        // Conversion ready, high
    output logic            miso_rdy_n_o,   // Ready on serial out, low
    output logic            miso_rdy_oe_o,  // Serial out enable for ready
    output logic      [7:0] trim_o          // Loaded trim word
);

    // ****************************************
    // Timing constants
    // ****************************************
    localparam int          MCLK_DIV  = `SGM_CLK_HZ / `SGM_MCLK_HZ;
    localparam int          READY_CYC = MCLK_DIV * FS_DIV;
    localparam logic [4:0]  MDIV_LAST = 5'(MCLK_DIV - 1);
    localparam logic [7:0]  FDIV_LAST = 8'(FS_DIV - 1);
    localparam logic [15:0] RDY_LAST  = 16'(READY_CYC - 1);
    localparam logic [16:0] BOOT_LAST = 17'(BOOT_CYC - 1);
    localparam logic [16:0] WAKE_LAST = 17'(WAKE_CYC - 1);

    sgm_pkg::sgm_state_t state_ff;
    sgm_pkg::sgm_state_t nxt_state;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.fs_tick = 1'b0;

        // R5: always sampling
        nxt_state.pad_s1 = gpio_pad_i;
        nxt_state.pad_s2 = state_ff.pad_s1;
        nxt_state.low_s1 = battery_supply_low_i;
        nxt_state.low_s2 = state_ff.low_s1;

        // R11: power sequence
        unique case (state_ff.pwr)
            sgm_pkg::PWR_BOOT:
            begin
                // R12: bounded boot time
                if (state_ff.cnt == BOOT_LAST)
                begin
                    nxt_state.trim = trim_i;
                    nxt_state.cnt  = '0;
                    nxt_state.pwr  = sgm_pkg::PWR_SLEEP;
                end
                else
                begin
                    nxt_state.cnt = state_ff.cnt + 17'h1;
                end
            end
            sgm_pkg::PWR_SLEEP:
            begin
                // R13: wake on traffic
                if (spi_wake_i)
                begin
                    nxt_state.pwr = sgm_pkg::PWR_WAKE;
                end
            end
            sgm_pkg::PWR_WAKE:
            begin
                // R13: bounded startup
                if (state_ff.cnt == WAKE_LAST)
                begin
                    nxt_state.cnt = '0;
                    nxt_state.pwr = sgm_pkg::PWR_RUN;
                end
                else
                begin
                    nxt_state.cnt = state_ff.cnt + 17'h1;
                end
            end
            sgm_pkg::PWR_RUN:
            begin
                if (sleep_req_i)
                begin
                    nxt_state.pwr = sgm_pkg::PWR_SLEEP;
                end
            end
        endcase
        nxt_state.osc_run = nxt_state.pwr != sgm_pkg::PWR_SLEEP;
        // R14: conversions gated
        nxt_state.conv_ok = nxt_state.pwr == sgm_pkg::PWR_RUN;

        // R10: master tick divider
        if (state_ff.conv_ok)
        begin
            if (state_ff.mdiv == MDIV_LAST)
            begin
                nxt_state.mdiv = '0;
                if (state_ff.fdiv == FDIV_LAST)
                begin
                    nxt_state.fdiv    = '0;
                    nxt_state.fs_tick = 1'b1;
                end
                else
                begin
                    nxt_state.fdiv = state_ff.fdiv + 8'h1;
                end
            end
            else
            begin
                nxt_state.mdiv = state_ff.mdiv + 5'h1;
            end
        end
        else
        begin
            nxt_state.mdiv = '0;
            nxt_state.fdiv = '0;
        end

        // R15: ready on completion
        if (conv_done_i && state_ff.conv_ok)
        begin
            nxt_state.ready   = 1'b1;
            nxt_state.rdy_cnt = RDY_LAST;
        end
        // R17: one sampling period
        else if (state_ff.ready)
        begin
            if (state_ff.rdy_cnt == '0)
            begin
                nxt_state.ready = 1'b0;
            end
            else
            begin
                nxt_state.rdy_cnt = state_ff.rdy_cnt - 16'h1;
            end
        end

        // ****************************************
        // Register access
        // ****************************************
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                `SGM_ADDR_OUT:  nxt_state.out_reg  = reg_wdata_i;
                `SGM_ADDR_MODE: nxt_state.mode_reg = reg_wdata_i;
                default:        ;
            endcase
        end
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `SGM_ADDR_OUT:  nxt_state.rdata = state_ff.out_reg;
                // R4: raw pin levels
                `SGM_ADDR_IN:   nxt_state.rdata = {6'h0, state_ff.pad_s2};
                `SGM_ADDR_MODE: nxt_state.rdata = state_ff.mode_reg;
                default:        nxt_state.rdata = 8'h00;
            endcase
        end

        // R7: reference bypass
        nxt_state.ref_out = nxt_state.mode_reg[`SGM_MODE_REF_OUT];
        nxt_state.ref_in  = nxt_state.mode_reg[`SGM_MODE_REF_IN];
        // R1: output enable
        // R2: released when clear
        nxt_state.gpio_oe[0] = nxt_state.out_reg[`SGM_OUT_DIR0] && !nxt_state.ref_out;
        nxt_state.gpio_oe[1] = nxt_state.out_reg[`SGM_OUT_DIR1] && !nxt_state.ref_in;
        // R6: data onto pins
        nxt_state.gpio = {nxt_state.out_reg[`SGM_OUT_DATA1], nxt_state.out_reg[`SGM_OUT_DATA0]};

        // R9: force-on wins
        // R8: force-off bypass
        nxt_state.pump_en = nxt_state.mode_reg[`SGM_MODE_FON]
            || (!nxt_state.mode_reg[`SGM_MODE_FOFF] && state_ff.low_s2);
        nxt_state.pump_bypass = !nxt_state.pump_en;

        // R16: active-low ready
        nxt_state.miso_rdy_oe = nxt_state.mode_reg[`SGM_MODE_RDY_MISO] && !spi_busy_i;
        nxt_state.miso_rdy_n  = !nxt_state.ready;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        // R3: direction reset
        if (rst_i)
        begin
            state_ff <= sgm_pkg::SGM_RST_STATE;
        end
        else if (ce_i)
        begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata_o   = state_ff.rdata;
    assign gpio_pad_o    = state_ff.gpio;
    assign gpio_pad_oe_o = state_ff.gpio_oe;
    assign ref_out_en_o  = state_ff.ref_out;
    assign ref_in_en_o   = state_ff.ref_in;
    assign pump_en_o     = state_ff.pump_en;
    assign pump_bypass_o = state_ff.pump_bypass;
    assign osc_run_o     = state_ff.osc_run;
    assign conv_ok_o     = state_ff.conv_ok;
    assign fs_tick_o     = state_ff.fs_tick;
    assign ready_o       = state_ff.ready;
    assign miso_rdy_n_o  = state_ff.miso_rdy_n;
    assign miso_rdy_oe_o = state_ff.miso_rdy_oe;
    assign trim_o        = state_ff.trim;

    // ****************************************
    // Checks
    // ****************************************
    // Helper counters that only the checks read.
    int rdy_len;
    int age;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdy_len <= 0;
            age     <= 0;
        end
        else if (ce_i)
        begin
            // A fresh completion restarts the pulse, so the length count restarts too.
            rdy_len <= (conv_done_i && state_ff.conv_ok) ? 0
                : (state_ff.ready ? rdy_len + 1 : 0);
            age     <= (nxt_state.pwr != state_ff.pwr) ? 0 : age + 1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    dir_drive_a: assert property ( // R1
        state_ff.out_reg[`SGM_OUT_DIR0] && !state_ff.ref_out |-> gpio_pad_oe_o[0])
        else $error("Pin zero not driven with direction set.");
    dir_hiz_a: assert property ( // R2
        !state_ff.out_reg[`SGM_OUT_DIR1] |-> !gpio_pad_oe_o[1])
        else $error("Pin one driven with direction clear.");
    reset_dir_a: assert property ( // R3
        $past(rst_i) |-> state_ff.out_reg == `SGM_OUT_RST)
        else $error("Direction bits not set after reset.");
    input_read_a: assert property ( // R4
        reg_rd_i && ce_i && reg_addr_i == `SGM_ADDR_IN
        |=> reg_rdata_o == {6'h0, $past(state_ff.pad_s2)})
        else $error("Input register does not show pin levels.");
    data_drive_a: assert property ( // R6
        gpio_pad_oe_o[1] |-> gpio_pad_o[1] == state_ff.out_reg[`SGM_OUT_DATA1])
        else $error("Pin one level differs from data bit.");
    ref_bypass_a: assert property ( // R7
        ref_in_en_o || ref_out_en_o |-> !(gpio_pad_oe_o[1] && ref_in_en_o)
        && !(gpio_pad_oe_o[0] && ref_out_en_o))
        else $error("Digital driver active on reference pin.");
    pump_off_a: assert property ( // R8
        state_ff.mode_reg[`SGM_MODE_FOFF] && !state_ff.mode_reg[`SGM_MODE_FON]
        |-> pump_bypass_o && !pump_en_o)
        else $error("Pump runs despite force-off.");
    pump_on_a: assert property ( // R9
        state_ff.mode_reg[`SGM_MODE_FON] |-> pump_en_o)
        else $error("Pump stopped despite force-on.");
    boot_time_a: assert property ( // R12
        state_ff.pwr == sgm_pkg::PWR_BOOT |-> age < BOOT_CYC)
        else $error("Boot exceeds its time limit.");
    wake_time_a: assert property ( // R13
        state_ff.pwr == sgm_pkg::PWR_WAKE |-> age < WAKE_CYC)
        else $error("Oscillator startup exceeds its limit.");
    ready_len_a: assert property ( // R17
        ce_i && state_ff.ready && !nxt_state.ready |-> rdy_len == READY_CYC - 1)
        else $error("Ready pulse length wrong.");
    miso_rdy_a: assert property ( // R16
        miso_rdy_oe_o |-> state_ff.mode_reg[`SGM_MODE_RDY_MISO] && miso_rdy_n_o == !ready_o)
        else $error("Serial ready driven while disabled.");

    wake_run_c: cover property (
        state_ff.pwr == sgm_pkg::PWR_WAKE ##1 state_ff.pwr == sgm_pkg::PWR_RUN);
    ready_c: cover property ($rose(ready_o));
    ref_c: cover property (ref_out_en_o && ref_in_en_o);

endmodule
`default_nettype wire

// ==== sgm_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Sensor side of the two pins
// ****************************************
module sgm_pin_model (
    input  wire logic [1:0] pad_o_i,   // Device drive values
    input  wire logic [1:0] pad_oe_i,  // Device output enables
    input  wire logic [1:0] ext_i,     // Sensor drive levels
    output logic      [1:0] pad_lvl_o  // Resolved pin levels
);
    // pin level resolution
    // A released pin shows the sensor level, so a stuck enable shows up on readback.
    always_comb
    begin
        for (int b = 0; b < 2; b++)
        begin
            pad_lvl_o[b] = pad_oe_i[b] ? pad_o_i[b] : ext_i[b];
        end
    end
endmodule

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int BOOT = 20;
    localparam int WAKE = 10;
    localparam int FSD  = 2;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       ce_i = 1'b1;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic       spi_wake_i = 1'b0;
    logic       sleep_req_i = 1'b0;
    logic [7:0] trim_i = 8'h5a;
    logic       conv_done_i = 1'b0;
    logic       spi_busy_i = 1'b0;
    logic [1:0] pad_lvl;
    logic [1:0] ext = 2'h0;
    logic [1:0] gpio_pad_o;
    logic [1:0] gpio_pad_oe_o;
    logic       battery_supply_low_i = 1'b0;
    logic       ref_out_en_o;
    logic       ref_in_en_o;
    logic       pump_en_o;
    logic       pump_bypass_o;
    logic       osc_run_o;
    logic       conv_ok_o;
    logic       fs_tick_o;
    logic       ready_o;
    logic       miso_rdy_n_o;
    logic       miso_rdy_oe_o;
    logic [7:0] trim_o;
    logic       rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    integer     seed = 95;
    integer     v;
    int         n;
    int         mismatches = 0;
    int         tests_run = 0;

    always #5 clk_i = ~clk_i;

    sgm_gpio_mode_ctrl #(.BOOT_CYC(BOOT), .WAKE_CYC(WAKE), .FS_DIV(FSD)) sgm_gpio_mode_ctrl_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .spi_wake_i(spi_wake_i), .sleep_req_i(sleep_req_i), .trim_i(trim_i),
        .conv_done_i(conv_done_i), .spi_busy_i(spi_busy_i), .gpio_pad_i(pad_lvl),
        .gpio_pad_o(gpio_pad_o), .gpio_pad_oe_o(gpio_pad_oe_o), .ref_out_en_o(ref_out_en_o),
        .ref_in_en_o(ref_in_en_o), .battery_supply_low_i(battery_supply_low_i), .pump_en_o(pump_en_o),
        .pump_bypass_o(pump_bypass_o), .osc_run_o(osc_run_o), .conv_ok_o(conv_ok_o),
        .fs_tick_o(fs_tick_o), .ready_o(ready_o), .miso_rdy_n_o(miso_rdy_n_o),
        .miso_rdy_oe_o(miso_rdy_oe_o), .trim_o(trim_o));

    sgm_pin_model sgm_pin_model_i (
        .pad_o_i(gpio_pad_o), .pad_oe_i(gpio_pad_oe_o), .ext_i(ext), .pad_lvl_o(pad_lvl));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        exp_q.push_back(e);
        @(negedge clk_i);
        reg_rd_i = 1'b0;
    endtask

    // ****************************************
    // Read data watcher
    // ****************************************
    always @(posedge clk_i)
        rd_seen <= reg_rd_i & ce_i;

    always @(negedge clk_i)
        if (rd_seen)
            chk(reg_rdata_o, exp_q.pop_front());

    initial
    begin
        #100us;
        mismatches++;
        end_of_test();
    end

    initial
    begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        chk({6'h0, gpio_pad_oe_o}, 8'h03);
        rd(8'h40, 8'h30);
        rd(8'h70, 8'h00);
        rd(8'h55, 8'h00);
        for (n = 0; n < BOOT + 4 && osc_run_o !== 1'b0; n++) @(negedge clk_i);
        chk({7'h0, osc_run_o}, 8'h00);
        chk(trim_o, trim_i);
        for (int i = 0; i < 8; i++)
        begin
            v = $random(seed);
            ext = v[9:8];
            wr(8'h40, {2'h0, v[5:4], 2'h0, v[1:0]});
            wr(8'h41, 8'hff);
            repeat (3) @(negedge clk_i);
            chk({6'h0, gpio_pad_oe_o}, {6'h0, v[5:4]});
            chk({6'h0, gpio_pad_o & v[5:4]}, {6'h0, v[1:0] & v[5:4]});
            rd(8'h41, {6'h0, (v[1:0] & v[5:4]) | (v[9:8] & ~v[5:4])});
        end
        ce_i = 1'b0;
        wr(8'h40, 8'h00);
        ce_i = 1'b1;
        rd(8'h40, {2'h0, v[5:4], 2'h0, v[1:0]});
        for (int m = 0; m < 16; m++)
        begin
            v = $random(seed);
            battery_supply_low_i = v[0];
            wr(8'h70, 8'(m));
            repeat (4) @(negedge clk_i);
            chk({6'h0, ref_in_en_o, ref_out_en_o}, 8'(m & 3));
            n = int'(m[3] | (~m[2] & v[0]));
            chk({6'h0, pump_bypass_o, pump_en_o}, 8'(n == 1 ? 1 : 2));
            rd(8'h70, 8'(m));
        end
        wr(8'h70, 8'h10);
        conv_done_i = 1'b1;
        @(negedge clk_i);
        conv_done_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk({7'h0, ready_o}, 8'h00);
        spi_wake_i = 1'b1;
        @(negedge clk_i);
        spi_wake_i = 1'b0;
        for (n = 0; n < WAKE + 4 && conv_ok_o !== 1'b1; n++) @(negedge clk_i);
        chk({7'h0, conv_ok_o}, 8'h01);
        chk({7'h0, osc_run_o}, 8'h01);
        while (fs_tick_o !== 1'b1 && n < 500) n++;
        for (n = 0; n < 200 && fs_tick_o !== 1'b1; n++) @(negedge clk_i);
        @(negedge clk_i);
        for (n = 1; n < 200 && fs_tick_o !== 1'b1; n++) @(negedge clk_i);
        chk(8'(n), 8'(25 * FSD));
        conv_done_i = 1'b1;
        @(negedge clk_i);
        conv_done_i = 1'b0;
        chk({6'h0, miso_rdy_oe_o, miso_rdy_n_o}, 8'h02);
        for (n = 0; n < 200 && ready_o === 1'b1; n++) @(negedge clk_i);
        chk(8'(n), 8'(25 * FSD));
        chk({6'h0, miso_rdy_oe_o, miso_rdy_n_o}, 8'h03);
        conv_done_i = 1'b1;
        spi_busy_i = 1'b1;
        @(negedge clk_i);
        conv_done_i = 1'b0;
        chk({6'h0, miso_rdy_oe_o, miso_rdy_n_o}, 8'h00);
        spi_busy_i = 1'b0;
        @(negedge clk_i);
        chk({6'h0, miso_rdy_oe_o, miso_rdy_n_o}, 8'h02);
        chk({7'h0, ready_o}, 8'h01);
        sleep_req_i = 1'b1;
        @(negedge clk_i);
        sleep_req_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk({6'h0, conv_ok_o, osc_run_o}, 8'h00);
        end_of_test();
    end
endmodule

`default_nettype wire
